// *** logic/cpc_clock_ctrl.sv ***
// Module: clock prescaler, PLL control and dynamic clock switch registers
//
// Overview of operation
// - Reset loads factory trim; software may overwrite
// - Trim code maps monotonically onto frequency
// - Divider unlock sets only with others zero
// - Divider unlock clears after four cycles
// - Rewriting divider unlock neither restarts nor clears
// - Reserved bits ignore writes, read zero
// - Divider changes only after unlock sequence
// - Divider reset value follows divide-by-eight fuse
// - Any divider value accepted regardless of fuse
// - Divider code n divides by two^n up to eight; codes above eight divide by 256
// - PLL factor codes two to six valid
// - PLL enable also starts RC reference
// - PLL enable reads one while PLL drives system
// - Lock flag set once PLL locked
// - RC select: zero 8MHz, one 1MHz
// - RC select writable only while RC runs
// - Command unlock set, timeout, rewrite like divider
// - Command acts only after unlock sequence
// - Command codes decode per command table
// - Ready flag clears on request, sets later
// - Disable of system source is ignored
// - Recover writes system source into holder
// - Availability counts ticks of selected source
// - Divider change glitch free, two edges
`timescale 1ns/1ps
`default_nettype none
module cpc_clock_ctrl (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Wishbone classic slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [9:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // Fuse values, caught after reset release
  input  wire logic [7:0]  FUSE_TRIM,
  input  wire logic        FUSE_DIV8,
  input  wire logic [3:0]  FUSE_CSEL,
  input  wire logic [1:0]  FUSE_CSUT,
  input  wire logic        FUSE_COUT,
  // Analog and source side
  input  wire logic        PLL_LOCK,
  input  wire logic [15:0] SRC_TICK,
  output logic      [7:0]  TRIM_OUT,
  output logic             RC_ENABLE,
  output logic             RC_FREQ_1M,
  output logic             PLL_ENABLE,
  output logic      [3:0]  PLL_FACTOR,
  output logic             PLL_FACTOR_OK,
  output logic      [15:0] SRC_ENABLE,
  output logic      [3:0]  SYS_SRC,
  output logic             SYS_CLK_EN,
  output logic             CLK_OUT_EN
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] startup_len(input logic [1:0] code);
    unique case (code)
      2'h0: startup_len = cpc_pkg::STARTUP_LEN0;
      2'h1: startup_len = cpc_pkg::STARTUP_LEN1;
      2'h2: startup_len = cpc_pkg::STARTUP_LEN2;
      2'h3: startup_len = cpc_pkg::STARTUP_LEN3;
    endcase
  endfunction

  // Reserved divider codes hold the slowest legal rate
  function automatic logic [7:0] div_mask(input logic [3:0] n);
    logic [3:0] m;
    m = (n > cpc_pkg::DIV_MAX) ? cpc_pkg::DIV_MAX : n;
    div_mask = 8'(9'((9'h001 << m) - 9'h001));
  endfunction

  // Unlock word: bit 7 alone, so a stray data write never opens a window
  function automatic logic is_unlock(input logic [7:0] d);
    is_unlock = (d == cpc_pkg::UNLOCK_WORD);
  endfunction

  // Data word: bit 7 low; only acted on while the window is open
  function automatic logic is_data(input logic [7:0] d);
    is_data = !d[cpc_pkg::UNLOCK_BIT];
  endfunction

  cpc_pkg::cpc_state_type s_q;
  cpc_pkg::cpc_state_type s_d;

  logic       req;
  logic       wr;
  logic [7:0] idx;
  logic [7:0] wd;
  logic       rc_run;
  logic       pll_eff;
  logic       sys_is_pll;
  logic       div_win;
  logic       cmd_win;

  assign req        = CYC_I & STB_I & ~s_q.ack;
  assign wr         = req & WE_I & SEL_I[0];
  assign idx        = ADR_I[9:2];
  assign wd         = DAT_I[7:0];
  assign sys_is_pll = (s_q.sys_src == cpc_pkg::SRC_PLL);
  assign pll_eff    = s_q.pll_on | sys_is_pll;
  assign rc_run     = s_q.src_en[cpc_pkg::SRC_RC] | pll_eff;
  assign div_win    = wr & (idx == cpc_pkg::IDX_DIV_CTRL);
  assign cmd_win    = wr & (idx == cpc_pkg::IDX_CMD_STAT);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Fuse straps caught in the first cycle after reset release
    if (!s_q.init_done) begin
      s_d.init_done = 1'b1;
      s_d.trim      = FUSE_TRIM;
      s_d.div_sel   = FUSE_DIV8 ? cpc_pkg::DIV_FUSE_RST : 4'h0;
      s_d.div_active = s_d.div_sel;
      s_d.sel_csel  = FUSE_CSEL;
      s_d.sel_csut  = FUSE_CSUT;
      s_d.sel_cout  = FUSE_COUT;
      s_d.sys_src   = FUSE_CSEL;
      s_d.src_en    = 16'h0000;
      s_d.src_en[FUSE_CSEL] = 1'b1;
    end

    // --------------------------------------------------------------
    // Unlock windows
    // --------------------------------------------------------------
    if (s_q.div_unlock) begin
      s_d.div_cnt = 3'(s_q.div_cnt + 3'h1);
      if (s_d.div_cnt == cpc_pkg::UNLOCK_CYCLES) begin
        s_d.div_unlock = 1'b0;
      end
    end
    if (s_q.cmd_unlock) begin
      s_d.cmd_cnt = 3'(s_q.cmd_cnt + 3'h1);
      if (s_d.cmd_cnt == cpc_pkg::UNLOCK_CYCLES) begin
        s_d.cmd_unlock = 1'b0;
      end
    end

    // --------------------------------------------------------------
    // Prescaler: new divider only at an active edge of the old one
    // --------------------------------------------------------------
    s_d.presc_cnt = 8'(s_q.presc_cnt + 8'h01);
    s_d.sys_en    = 1'b0;
    if ((s_q.presc_cnt & div_mask(s_q.div_active)) == 8'h00) begin
      s_d.sys_en     = 1'b1;
      s_d.div_active = s_q.div_sel;
      s_d.presc_cnt  = 8'h01;
    end

    // --------------------------------------------------------------
    // PLL lock and RC select upkeep
    // --------------------------------------------------------------
    s_d.pll_locked = pll_eff & PLL_LOCK;
    if (sys_is_pll) begin
      s_d.pll_on = 1'b1;
    end
    if (!rc_run) begin
      s_d.rc_freq = 1'b0;
    end

    // --------------------------------------------------------------
    // Availability counter
    // --------------------------------------------------------------
    if (s_q.avail_busy && SRC_TICK[s_q.avail_src]) begin
      s_d.avail_cnt = 10'(s_q.avail_cnt - 10'h001);
      if (s_q.avail_cnt == 10'h001) begin
        s_d.avail_busy = 1'b0;
        s_d.clk_ready  = 1'b1;
      end
    end

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    if (wr) begin
      unique case (idx)
        cpc_pkg::IDX_TRIM: begin
          s_d.trim = wd;
        end
        cpc_pkg::IDX_PLL_CTRL: begin
          s_d.pll_factor = wd[5:2];
          s_d.pll_on     = wd[cpc_pkg::PLL_ON_BIT] | sys_is_pll;
        end
        cpc_pkg::IDX_CORE_CTRL: begin
          s_d.core_misc = {wd[4:3], wd[1:0]};
          if (rc_run) begin
            s_d.rc_freq = wd[cpc_pkg::RC_FREQ_BIT];
          end
        end
        cpc_pkg::IDX_SEL_HOLD: begin
          s_d.sel_cout = wd[6];
          s_d.sel_csut = wd[5:4];
          s_d.sel_csel = wd[3:0];
        end
        default: begin
        end
      endcase
    end

    // Divider control writes
    if (div_win) begin
      if (is_unlock(wd)) begin
        if (!s_q.div_unlock) begin
          s_d.div_unlock = 1'b1;
          s_d.div_cnt    = 3'h0;
        end
      end else if (is_data(wd) && s_q.div_unlock) begin
        s_d.div_sel    = wd[3:0];
        s_d.div_unlock = 1'b0;
      end
    end

    // Command writes
    if (cmd_win) begin
      if (is_unlock(wd)) begin
        if (!s_q.cmd_unlock) begin
          s_d.cmd_unlock = 1'b1;
          s_d.cmd_cnt    = 3'h0;
        end
      end else if (is_data(wd) && s_q.cmd_unlock) begin
        s_d.cmd_unlock = 1'b0;
        s_d.cmd_code   = wd[3:0];
        unique case (wd[3:0])
          cpc_pkg::CMD_DISABLE: begin
            if (s_q.sel_csel != s_q.sys_src) begin
              s_d.src_en[s_q.sel_csel] = 1'b0;
            end
          end
          cpc_pkg::CMD_ENABLE: begin
            s_d.src_en[s_q.sel_csel] = 1'b1;
          end
          cpc_pkg::CMD_AVAIL: begin
            s_d.clk_ready  = 1'b0;
            s_d.avail_busy = 1'b1;
            s_d.avail_src  = s_q.sel_csel;
            s_d.avail_cnt  = startup_len(s_q.sel_csut);
          end
          cpc_pkg::CMD_SWITCH: begin
            if (s_q.src_en[s_q.sel_csel]) begin
              s_d.sys_src = s_q.sel_csel;
            end
          end
          cpc_pkg::CMD_RECOVER: begin
            s_d.sel_csel = s_q.sys_src;
          end
          cpc_pkg::CMD_CLKOUT: begin
            s_d.clk_out_en = s_q.sel_cout;
          end
          default: begin
            // Code 0110 and 1xxx leave every source alone
          end
        endcase
      end
      // Outside the window the write is dropped whole
    end

    // --------------------------------------------------------------
    // Bus answer: ack one cycle after the request, data from flip-flops
    // --------------------------------------------------------------
    s_d.ack   = req;
    s_d.rdata = 8'h00;
    if (req && !WE_I) begin
      unique case (idx)
        cpc_pkg::IDX_TRIM:      s_d.rdata = s_q.trim;
        cpc_pkg::IDX_DIV_CTRL:  s_d.rdata = {s_q.div_unlock, 3'h0, s_q.div_sel};
        cpc_pkg::IDX_PLL_CTRL:  s_d.rdata = {2'h0, s_q.pll_factor, pll_eff, s_q.pll_locked};
        cpc_pkg::IDX_CORE_CTRL: s_d.rdata = {3'h0, s_q.core_misc[3:2], s_q.rc_freq,
                                             s_q.core_misc[1:0]};
        cpc_pkg::IDX_CMD_STAT:  s_d.rdata = {s_q.cmd_unlock, 2'h0, s_q.clk_ready,
                                             s_q.cmd_code};
        cpc_pkg::IDX_SEL_HOLD:  s_d.rdata = {1'b0, s_q.sel_cout, s_q.sel_csut, s_q.sel_csel};
        default:                s_d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q            <= '0;
      s_q.pll_factor <= cpc_pkg::PLL_FACTOR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign DAT_O         = {24'h000000, s_q.rdata};
  assign ACK_O         = s_q.ack;
  assign TRIM_OUT      = s_q.trim;
  assign RC_ENABLE     = rc_run;
  assign RC_FREQ_1M    = s_q.rc_freq;
  assign PLL_ENABLE    = pll_eff;
  assign PLL_FACTOR    = s_q.pll_factor;
  assign PLL_FACTOR_OK = (s_q.pll_factor >= cpc_pkg::PLL_FACTOR_MIN) &&
                         (s_q.pll_factor <= cpc_pkg::PLL_FACTOR_MAX);
  assign SRC_ENABLE    = s_q.src_en;
  assign SYS_SRC       = s_q.sys_src;
  assign SYS_CLK_EN    = s_q.sys_en;
  assign CLK_OUT_EN    = s_q.clk_out_en;

endmodule // cpc_clock_ctrl
`default_nettype wire

// *** logic/cpc_pkg.sv ***
// Package: constants and state types of the clock prescale and switch control
`default_nettype none
package cpc_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PLL_CTRL  = 8'h29;
  localparam logic [7:0] IDX_TRIM      = 8'h26;
  localparam logic [7:0] IDX_DIV_CTRL  = 8'h21;
  localparam logic [7:0] IDX_CORE_CTRL = 8'h35;
  localparam logic [7:0] IDX_CMD_STAT  = 8'h2A;
  localparam logic [7:0] IDX_SEL_HOLD  = 8'h2B;
  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int          UNLOCK_BIT     = 7;
  localparam int          READY_BIT      = 4;
  localparam int          RC_FREQ_BIT    = 2;
  localparam int          PLL_ON_BIT     = 1;
  localparam logic [7:0]  UNLOCK_WORD    = 8'h80;
  localparam logic [2:0]  UNLOCK_CYCLES  = 3'h4;
  localparam logic [3:0]  DIV_FUSE_RST   = 4'h3;
  localparam logic [3:0]  DIV_MAX        = 4'h8;
  localparam logic [3:0]  PLL_FACTOR_RST = 4'h4;
  localparam logic [3:0]  PLL_FACTOR_MIN = 4'h2;
  localparam logic [3:0]  PLL_FACTOR_MAX = 4'h6;
  localparam logic [3:0]  SRC_RC         = 4'h2;
  localparam logic [3:0]  SRC_PLL        = 4'h3;
  localparam logic [9:0]  STARTUP_LEN0   = 10'h010;
  localparam logic [9:0]  STARTUP_LEN1   = 10'h040;
  localparam logic [9:0]  STARTUP_LEN2   = 10'h100;
  localparam logic [9:0]  STARTUP_LEN3   = 10'h3FF;
  // ----------------------------------------------------------------
  // Commands and state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE    = 4'b0000,
    CMD_DISABLE = 4'b0001,
    CMD_ENABLE  = 4'b0010,
    CMD_AVAIL   = 4'b0011,
    CMD_SWITCH  = 4'b0100,
    CMD_RECOVER = 4'b0101,
    CMD_CLKOUT  = 4'b0111
  } cpc_cmd_type;

  typedef struct packed {
    logic        init_done;
    logic [7:0]  trim;
    logic        div_unlock;
    logic [2:0]  div_cnt;
    logic [3:0]  div_sel;
    logic [3:0]  div_active;
    logic [7:0]  presc_cnt;
    logic        sys_en;
    logic [3:0]  pll_factor;
    logic        pll_on;
    logic        pll_locked;
    logic        rc_freq;
    logic [3:0]  core_misc;
    logic        cmd_unlock;
    logic [2:0]  cmd_cnt;
    logic [3:0]  cmd_code;
    logic        clk_ready;
    logic        avail_busy;
    logic [3:0]  avail_src;
    logic [9:0]  avail_cnt;
    logic        sel_cout;
    logic [1:0]  sel_csut;
    logic [3:0]  sel_csel;
    logic [3:0]  sys_src;
    logic [15:0] src_en;
    logic        clk_out_en;
    logic        ack;
    logic [7:0]  rdata;
  } cpc_state_type;
endpackage
`default_nettype wire

// *** test/cpc_clock_ctrl_assertions.sv ***
// Checker: bus and control relations of the clock control block
`timescale 1ns/1ps
`default_nettype none
module cpc_clock_ctrl_assertions (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // Register bus
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [9:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  // Control outputs
  input wire logic [7:0]  TRIM_OUT,
  input wire logic        RC_ENABLE,
  input wire logic        RC_FREQ_1M,
  input wire logic        PLL_ENABLE,
  input wire logic [3:0]  PLL_FACTOR,
  input wire logic        PLL_FACTOR_OK,
  input wire logic [3:0]  SYS_SRC
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic       take;
  logic [7:0] idx;
  assign take = CYC_I && STB_I && !ACK_O;
  assign idx  = ADR_I[9:2];

  AST_ACK_NEXT: assert property (take |=> ACK_O)
    else $error("request not acknowledged in next cycle");
  AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
    else $error("acknowledge longer than one cycle");
  AST_TRIM_WR: assert property (take && WE_I && SEL_I[0] && idx == cpc_pkg::IDX_TRIM
    |=> TRIM_OUT == $past(DAT_I[7:0])) else $error("trim write not applied");
  AST_DIV_RSV: assert property (ACK_O && !WE_I && idx == cpc_pkg::IDX_DIV_CTRL
    |-> DAT_O[6:4] == 3'h0) else $error("divider reserved bits nonzero");
  AST_PLL_RSV: assert property (ACK_O && !WE_I && idx == cpc_pkg::IDX_PLL_CTRL
    |-> DAT_O[7:6] == 2'h0) else $error("pll reserved bits nonzero");
  AST_CMD_RSV: assert property (ACK_O && !WE_I && idx == cpc_pkg::IDX_CMD_STAT
    |-> DAT_O[6:5] == 2'h0) else $error("command reserved bits nonzero");
  AST_PLL_SYS: assert property (SYS_SRC == cpc_pkg::SRC_PLL |-> PLL_ENABLE)
    else $error("pll enable low while pll drives system");
  AST_PLL_REF: assert property (PLL_ENABLE |-> RC_ENABLE)
    else $error("pll on without reference oscillator");
  AST_FACTOR: assert property (PLL_FACTOR_OK == (PLL_FACTOR >= cpc_pkg::PLL_FACTOR_MIN
    && PLL_FACTOR <= cpc_pkg::PLL_FACTOR_MAX)) else $error("factor valid flag wrong");
  AST_RC_CLR: assert property (!RC_ENABLE |=> !RC_FREQ_1M)
    else $error("rc frequency select not cleared while oscillator off");
endmodule // cpc_clock_ctrl_assertions
`default_nettype wire

// *** test/cpc_clock_ctrl_tb.sv ***
// Testbench: register-level checks of the clock control block
`timescale 1ns/1ps
`default_nettype none
module cpc_clock_ctrl_tb;
  logic        clk, rst, cyc, stb, we, pll_lock;
  logic        ack, rc_1m, pll_en, fac_ok, sys_clk_en, clk_out_en;
  logic [3:0]  sel, sys_src;
  logic [9:0]  adr;
  logic [31:0] dat_wr, dat_rd;
  logic [15:0] tick, src_en;
  logic [7:0]  trim_out, rd;
  int          err_count, comparisons, cycles, p;

  cpc_clock_ctrl u_dut (
    .CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_wr), .DAT_O(dat_rd), .ACK_O(ack),
    .FUSE_TRIM(8'h5A), .FUSE_DIV8(1'b1), .FUSE_CSEL(cpc_pkg::SRC_RC),
    .FUSE_CSUT(2'h0), .FUSE_COUT(1'b0), .PLL_LOCK(pll_lock), .SRC_TICK(tick),
    .TRIM_OUT(trim_out), .RC_ENABLE(), .RC_FREQ_1M(rc_1m), .PLL_ENABLE(pll_en),
    .PLL_FACTOR(), .PLL_FACTOR_OK(fac_ok), .SRC_ENABLE(src_en), .SYS_SRC(sys_src),
    .SYS_CLK_EN(sys_clk_en), .CLK_OUT_EN(clk_out_en));

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // Request held until ack is sampled high at a rising edge; data taken there
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    dat_wr <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_rd[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(nm, {24'h0, rd}, {24'h0, exp});
  endtask
  // Nothing may come between the two writes
  task automatic unlocked(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, cpc_pkg::UNLOCK_WORD);
    wb(1'b1, idx, d);
  endtask
  task automatic period();
    do @(negedge clk); while (sys_clk_en !== 1'b1);
    p = 0;
    do begin
      @(negedge clk);
      p++;
    end while (sys_clk_en !== 1'b1);
  endtask
  task automatic ticks(input int s);
    repeat (cpc_pkg::STARTUP_LEN0) begin
      @(posedge clk);
      tick <= 16'h0001 << s;
      @(posedge clk);
      tick <= 16'h0000;
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, pll_lock} = 4'h0;
    sel = 4'hF;
    adr = 10'h000;
    dat_wr = 32'h0;
    tick = 16'h0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rchk("trim", cpc_pkg::IDX_TRIM, 8'h5A);
    rchk("divider", cpc_pkg::IDX_DIV_CTRL, 8'h03);
    rchk("pll", cpc_pkg::IDX_PLL_CTRL, 8'h10);
    rchk("command", cpc_pkg::IDX_CMD_STAT, 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
    wb(1'b1, cpc_pkg::IDX_TRIM, 8'h7F);
    chk("trim pin", {24'h0, trim_out}, 32'h7F);
    for (int n = 0; n <= 9; n++) begin
      unlocked(cpc_pkg::IDX_DIV_CTRL, 8'(n));
      rchk("divider", cpc_pkg::IDX_DIV_CTRL, 8'(n));
      period();
      period();
      chk("period", p, (n > 8) ? 256 : (1 << n));
    end
    wb(1'b1, cpc_pkg::IDX_DIV_CTRL, 8'h02);
    wb(1'b1, cpc_pkg::IDX_DIV_CTRL, 8'h81);
    wb(1'b1, cpc_pkg::IDX_DIV_CTRL, 8'h02);
    wb(1'b1, cpc_pkg::IDX_DIV_CTRL, 8'h80);
    repeat (3) @(posedge clk);
    wb(1'b1, cpc_pkg::IDX_DIV_CTRL, 8'h02);
    wb(1'b1, cpc_pkg::IDX_DIV_CTRL, 8'h80);
    wb(1'b1, cpc_pkg::IDX_DIV_CTRL, 8'h80);
    wb(1'b1, cpc_pkg::IDX_DIV_CTRL, 8'h02);
    rchk("divider", cpc_pkg::IDX_DIV_CTRL, 8'h09);
    pll_lock <= 1'b1;
    wb(1'b1, cpc_pkg::IDX_PLL_CTRL, 8'hFF);
    rchk("pll", cpc_pkg::IDX_PLL_CTRL, 8'h3F);
    chk("pll enable", pll_en, 1'b1);
    wb(1'b1, cpc_pkg::IDX_PLL_CTRL, 8'h10);
    rchk("pll", cpc_pkg::IDX_PLL_CTRL, 8'h10);
    pll_lock <= 1'b0;
    for (int f = 0; f < 16; f++) begin
      wb(1'b1, cpc_pkg::IDX_PLL_CTRL, 8'(f << 2));
      chk("factor ok", fac_ok, (f >= 2 && f <= 6));
    end
    wb(1'b1, cpc_pkg::IDX_PLL_CTRL, 8'h10);
    wb(1'b1, cpc_pkg::IDX_CORE_CTRL, 8'h04);
    rchk("core", cpc_pkg::IDX_CORE_CTRL, 8'h04);
    chk("rc 1m", rc_1m, 1'b1);
    wb(1'b1, cpc_pkg::IDX_CORE_CTRL, 8'h00);
    wb(1'b1, cpc_pkg::IDX_SEL_HOLD, 8'h03);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h02);
    chk("enables", src_en[3], 1'b1);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h03);
    rchk("command", cpc_pkg::IDX_CMD_STAT, 8'h03);
    ticks(3);
    rchk("command", cpc_pkg::IDX_CMD_STAT, 8'h13);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h03);
    rchk("command", cpc_pkg::IDX_CMD_STAT, 8'h03);
    ticks(3);
    rchk("command", cpc_pkg::IDX_CMD_STAT, 8'h13);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h04);
    chk("system source", sys_src, 4'h3);
    rchk("pll", cpc_pkg::IDX_PLL_CTRL, 8'h12);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h01);
    chk("enables", src_en[3], 1'b1);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h06);
    chk("system source", sys_src, 4'h3);
    chk("enables", src_en, 32'h0000000C);
    wb(1'b1, cpc_pkg::IDX_SEL_HOLD, 8'h40);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h05);
    rchk("holder", cpc_pkg::IDX_SEL_HOLD, 8'h43);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h07);
    chk("clock out", clk_out_en, 1'b1);
    wb(1'b1, cpc_pkg::IDX_CMD_STAT, 8'h81);
    wb(1'b1, cpc_pkg::IDX_CMD_STAT, 8'h02);
    rchk("command", cpc_pkg::IDX_CMD_STAT, 8'h17);
    wb(1'b1, cpc_pkg::IDX_SEL_HOLD, 8'h00);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h02);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h04);
    chk("system source", sys_src, 4'h0);
    wb(1'b1, cpc_pkg::IDX_PLL_CTRL, 8'h10);
    wb(1'b1, cpc_pkg::IDX_CORE_CTRL, 8'h04);
    wb(1'b1, cpc_pkg::IDX_SEL_HOLD, 8'h02);
    unlocked(cpc_pkg::IDX_CMD_STAT, 8'h01);
    wb(1'b1, cpc_pkg::IDX_CORE_CTRL, 8'h04);
    chk("rc 1m", rc_1m, 1'b0);
    rchk("core", cpc_pkg::IDX_CORE_CTRL, 8'h00);
    print_verdict();
  end
endmodule // cpc_clock_ctrl_tb

bind cpc_clock_ctrl cpc_clock_ctrl_assertions u_chk (
  .CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
  .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .TRIM_OUT(TRIM_OUT),
  .RC_ENABLE(RC_ENABLE), .RC_FREQ_1M(RC_FREQ_1M), .PLL_ENABLE(PLL_ENABLE),
  .PLL_FACTOR(PLL_FACTOR),
  .PLL_FACTOR_OK(PLL_FACTOR_OK), .SYS_SRC(SYS_SRC));
`default_nettype wire
